/* hw/ecc_cap_if.sv */
`timescale 1ns/1ps
interface ecc_cap_if #(parameter int TW = 16);
    logic edge_stb;
    logic [TW-1:0] stamp;
    logic overwrite;
    logic rd_stb;
    logic [TW-1:0] time_q;
    logic time_full;
    logic buf_full;
    logic xfer_stb;
    logic ovr_stb;

    modport chan (
        input edge_stb, stamp, overwrite, rd_stb,
        output time_q, time_full, buf_full, xfer_stb, ovr_stb
    );
    modport ctl (
        output edge_stb, stamp, overwrite, rd_stb,
        input time_q, time_full, buf_full, xfer_stb, ovr_stb
    );
endinterface

/* hw/ecc_capture_chan.sv */
`timescale 1ns/1ps
module ecc_capture_chan #(
    parameter int TW = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // capture channel link
    ecc_cap_if.chan cp
);
    typedef struct packed {
        logic [TW-1:0] time_v;
        logic [TW-1:0] buf_v;
        logic tfull;
        logic bfull;
    } ecc_cap_st_t;

    ecc_cap_st_t s_r;
    ecc_cap_st_t s_nxt;
    logic xfer;
    logic ovr;

    // read pop first, then the edge sees the updated occupancy
    always_comb begin
        s_nxt = s_r;
        xfer = 1'b0;
        ovr = 1'b0;
        if (cp.rd_stb) begin
            if (s_r.bfull) begin
                s_nxt.time_v = s_r.buf_v;
                s_nxt.bfull = 1'b0;
                xfer = 1'b1;
            end else begin
                s_nxt.tfull = 1'b0;
            end
        end
        // a read and an edge in one cycle both land, so no pending bit is lost
        if (cp.edge_stb) begin
            if (!s_nxt.tfull) begin
                s_nxt.time_v = cp.stamp;
                s_nxt.tfull = 1'b1;
                xfer = 1'b1;
            end else if (!s_nxt.bfull) begin
                s_nxt.buf_v = cp.stamp;
                s_nxt.bfull = 1'b1;
            end else begin
                ovr = 1'b1;
                if (cp.overwrite) begin
                    s_nxt.buf_v = cp.stamp;
                end
                // overwrite clear: the edge is dropped
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // link outputs
    assign cp.time_q = s_r.time_v;
    assign cp.time_full = s_r.tfull;
    assign cp.buf_full = s_r.bfull;
    assign cp.xfer_stb = xfer;
    assign cp.ovr_stb = ovr;
endmodule

/* hw/ecc_pkg.sv */
package ecc_pkg;
    // register byte offsets
    localparam logic [11:0] ECC_TCTRL_OFF = 12'h000;
    localparam logic [11:0] ECC_TIMER_OFF = 12'h004;
    localparam logic [11:0] ECC_PEND_OFF = 12'h008;
    localparam logic [11:0] ECC_MASK_OFF = 12'h00c;
    localparam logic [11:0] ECC_CH_BASE = 12'h040;
    localparam logic [11:0] ECC_CH_STRIDE = 12'h010;
    localparam logic [11:0] ECC_CON_OFF = 12'h000;
    localparam logic [11:0] ECC_TIME_OFF = 12'h004;
    localparam logic [11:0] ECC_CMP_OFF = 12'h008;

    // timer control fields
    localparam int ECC_TW = 16;
    localparam int ECC_TC_RUN = 0;
    localparam int ECC_TC_DOWN = 1;
    localparam int ECC_TC_PRE_LSB = 8;
    localparam int ECC_TC_PRE_W = 8;

    // channel control fields
    localparam int ECC_CON_W = 6;
    localparam int ECC_CON_OVW = 0;
    localparam int ECC_CON_CAPEN = 1;
    localparam int ECC_CON_RISE = 2;
    localparam int ECC_CON_FALL = 3;
    localparam int ECC_CON_CMPEN = 4;
    localparam int ECC_CON_TRST = 5;
    localparam int ECC_CON_TFULL = 8;
    localparam int ECC_CON_BFULL = 9;

    // pending and mask layout: channel bits low, overrun bits from here up
    localparam int ECC_PEND_OVR_LSB = 16;

    // reset values
    localparam logic [31:0] ECC_DATA_RST = 32'h0000_0000;

    // bus handshake states, gray coded
    typedef enum logic [1:0] {
        ECC_BUS_IDLE = 2'b00,
        ECC_BUS_ACK = 2'b01
    } ecc_bus_t;

    // true when address a selects register sub of channel i
    function automatic logic ecc_ch_hit(input logic [11:0] a, input int i, input logic [11:0] sub);
        logic [11:0] base;
        base = 12'(ECC_CH_BASE + ECC_CH_STRIDE * 12'(i));
        return a == 12'(base + sub);
    endfunction
endpackage

/* hw/ecc_top.sv */
`timescale 1ns/1ps
// Functional notes
// - A software timer write and a channel-driven timer reset in the same cycle have no promised winner; here the reset wins.
// - A compare match is flagged only when the timer counts up or down onto the compare value.
// - A timer reset to zero never makes a match, even with a compare value of zero.
// - With overwrite set, an edge arriving on a full channel replaces the buffered capture.
// - Overwrite, overrunning edges and a time read in the same instant may meet; this design loses no pending bit then.
// - An edge that arrives while both time register and buffer are full is an overrun.
// - Reading the capture time moves the buffered value into it and empties the buffer.
// - The channel pending bit is set by the move into the time register, not by the pin edge.
// - With overwrite clear and both stores full, further edges are ignored until the time is read.
// - An overrun sets the channel overrun flag in the overrun pending register.
module ecc_top
    import ecc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int TW = ECC_TW
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event input pins
    input wire logic [NCH-1:0] evt_pin,
    // interrupt
    output logic irq
);
    typedef struct packed {
        ecc_bus_t bus;
        logic [31:0] rdata;
        logic err;
        logic [TW-1:0] timer;
        logic [ECC_TC_PRE_W-1:0] pre_cnt;
        logic [ECC_TC_PRE_W-1:0] pre;
        logic run;
        logic down;
        logic [NCH-1:0][ECC_CON_W-1:0] con;
        logic [NCH-1:0][TW-1:0] cmp;
        logic [NCH-1:0] pend_ch;
        logic [NCH-1:0] pend_ovr;
        logic [NCH-1:0] mask_ch;
        logic [NCH-1:0] mask_ovr;
        logic [NCH-1:0] pin_prev;
        logic irq;
    } ecc_state_t;

    ecc_state_t st_r;
    ecc_state_t st_nxt;
    logic [NCH-1:0] edge_stb;
    logic [NCH-1:0] rd_stb;
    logic [NCH-1:0] xfer;
    logic [NCH-1:0] ovr;
    logic [NCH-1:0] tfull;
    logic [NCH-1:0] bfull;
    logic [NCH-1:0][TW-1:0] time_q;
    logic setup_rd;

    ecc_cap_if #(.TW(TW)) cap_if[NCH] ();

    // a read of a time register pops it on the edge that latches read data
    assign setup_rd = psel && penable && !pwrite && (st_r.bus == ECC_BUS_IDLE);

    // per-channel edge detect and capture units
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign edge_stb[g] = st_r.con[g][ECC_CON_CAPEN]
            && ((evt_pin[g] && !st_r.pin_prev[g] && st_r.con[g][ECC_CON_RISE])
            || (!evt_pin[g] && st_r.pin_prev[g] && st_r.con[g][ECC_CON_FALL]));
        assign rd_stb[g] = setup_rd && ecc_ch_hit(paddr, g, ECC_TIME_OFF);
        assign cap_if[g].edge_stb = edge_stb[g];
        assign cap_if[g].stamp = st_r.timer;
        assign cap_if[g].overwrite = st_r.con[g][ECC_CON_OVW];
        assign cap_if[g].rd_stb = rd_stb[g];
        assign xfer[g] = cap_if[g].xfer_stb;
        assign ovr[g] = cap_if[g].ovr_stb;
        assign tfull[g] = cap_if[g].time_full;
        assign bfull[g] = cap_if[g].buf_full;
        assign time_q[g] = cap_if[g].time_q;
        ecc_capture_chan #(.TW(TW)) u_cap (
            .pclk(pclk),
            .presetn(presetn),
            .cp(cap_if[g].chan)
        );
    end

    // next-state logic: bus, timer, compare, pending and interrupt
    always_comb begin
        logic tick;
        logic hit;
        logic wr;
        logic trst;
        logic [31:0] rd;
        logic [TW-1:0] cnt_val;
        logic [NCH-1:0] match;
        logic [NCH-1:0] clr_ch;
        logic [NCH-1:0] clr_ovr;
        tick = 1'b0;
        hit = 1'b0;
        wr = 1'b0;
        trst = 1'b0;
        rd = ECC_DATA_RST;
        cnt_val = '0;
        match = '0;
        clr_ch = '0;
        clr_ovr = '0;
        st_nxt = st_r;
        st_nxt.pin_prev = evt_pin;

        // register decode and read mux
        if (paddr == ECC_TCTRL_OFF) begin
            hit = 1'b1;
            rd[ECC_TC_RUN] = st_r.run;
            rd[ECC_TC_DOWN] = st_r.down;
            rd[ECC_TC_PRE_LSB +: ECC_TC_PRE_W] = st_r.pre;
        end else if (paddr == ECC_TIMER_OFF) begin
            hit = 1'b1;
            rd[TW-1:0] = st_r.timer;
        end else if (paddr == ECC_PEND_OFF) begin
            hit = 1'b1;
            rd[NCH-1:0] = st_r.pend_ch;
            rd[ECC_PEND_OVR_LSB +: NCH] = st_r.pend_ovr;
        end else if (paddr == ECC_MASK_OFF) begin
            hit = 1'b1;
            rd[NCH-1:0] = st_r.mask_ch;
            rd[ECC_PEND_OVR_LSB +: NCH] = st_r.mask_ovr;
        end
        for (int i = 0; i < NCH; i++) begin
            if (ecc_ch_hit(paddr, i, ECC_CON_OFF)) begin
                hit = 1'b1;
                rd[ECC_CON_W-1:0] = st_r.con[i];
                rd[ECC_CON_TFULL] = tfull[i];
                rd[ECC_CON_BFULL] = bfull[i];
            end else if (ecc_ch_hit(paddr, i, ECC_TIME_OFF)) begin
                hit = 1'b1;
                rd[TW-1:0] = time_q[i];
            end else if (ecc_ch_hit(paddr, i, ECC_CMP_OFF)) begin
                hit = 1'b1;
                rd[TW-1:0] = st_r.cmp[i];
            end
        end

        // two-phase handshake: data latched on entry to ack, writes on leaving it
        case (st_r.bus)
            ECC_BUS_IDLE: begin
                if (psel && penable) begin
                    st_nxt.bus = ECC_BUS_ACK;
                    st_nxt.rdata = pwrite ? ECC_DATA_RST : rd;
                    st_nxt.err = !hit;
                end
            end
            ECC_BUS_ACK: begin
                st_nxt.bus = ECC_BUS_IDLE;
                st_nxt.rdata = ECC_DATA_RST;
                st_nxt.err = 1'b0;
                wr = psel && penable && pwrite;
            end
            default: begin
                st_nxt.bus = ECC_BUS_IDLE;
            end
        endcase

        // register writes
        if (wr) begin
            if (paddr == ECC_TCTRL_OFF) begin
                st_nxt.run = pwdata[ECC_TC_RUN];
                st_nxt.down = pwdata[ECC_TC_DOWN];
                st_nxt.pre = pwdata[ECC_TC_PRE_LSB +: ECC_TC_PRE_W];
            end
            if (paddr == ECC_PEND_OFF) begin
                clr_ch = pwdata[NCH-1:0];
                clr_ovr = pwdata[ECC_PEND_OVR_LSB +: NCH];
            end
            if (paddr == ECC_MASK_OFF) begin
                st_nxt.mask_ch = pwdata[NCH-1:0];
                st_nxt.mask_ovr = pwdata[ECC_PEND_OVR_LSB +: NCH];
            end
            for (int i = 0; i < NCH; i++) begin
                if (ecc_ch_hit(paddr, i, ECC_CON_OFF)) begin
                    st_nxt.con[i] = pwdata[ECC_CON_W-1:0];
                end
                if (ecc_ch_hit(paddr, i, ECC_CMP_OFF)) begin
                    st_nxt.cmp[i] = pwdata[TW-1:0];
                end
            end
        end

        // prescaler gives one count enable per period
        if (st_r.run) begin
            tick = (st_r.pre_cnt == st_r.pre);
            st_nxt.pre_cnt = tick ? '0 : ECC_TC_PRE_W'(st_r.pre_cnt + 1'b1);
        end
        cnt_val = st_r.down ? TW'(st_r.timer - 1'b1) : TW'(st_r.timer + 1'b1);

        // matches only from counting; loads and resets never compare
        for (int i = 0; i < NCH; i++) begin
            match[i] = tick && st_r.con[i][ECC_CON_CMPEN] && (cnt_val == st_r.cmp[i]);
            trst = trst || (st_r.con[i][ECC_CON_TRST] && (match[i] || edge_stb[i]));
        end

        // timer: count, then software load, then channel reset wins
        if (tick) begin
            st_nxt.timer = cnt_val;
        end
        if (wr && paddr == ECC_TIMER_OFF) begin
            st_nxt.timer = pwdata[TW-1:0];
        end
        if (trst) begin
            st_nxt.timer = '0;
        end

        // sticky pending bits, a set beats a same-cycle clear
        st_nxt.pend_ch = (st_r.pend_ch & ~clr_ch) | xfer | match;
        st_nxt.pend_ovr = (st_r.pend_ovr & ~clr_ovr) | ovr;
        st_nxt.irq = |({st_nxt.pend_ovr, st_nxt.pend_ch} & {st_nxt.mask_ovr, st_nxt.mask_ch});
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign prdata = st_r.rdata;
    assign pready = st_r.bus[0]; // only the ack state has bit 0 set, so ready is a bare flop
    assign pslverr = st_r.err;
    assign irq = st_r.irq;
endmodule

/* sim/ecc_pin_drv.sv */
`timescale 1ns/1ps
module ecc_pin_drv #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // toggle request and pins
    input wire logic [N-1:0] flip,
    output logic [N-1:0] evt_pin
);
    // each requested pin changes level once, synchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) evt_pin <= '0;
        else evt_pin <= evt_pin ^ flip;
    end
endmodule

/* sim/ecc_top_chk.sv */
`timescale 1ns/1ps
module ecc_top_chk #(
    parameter int NCH = 4,
    parameter int TW = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and interrupt
    input wire logic [NCH-1:0] evt_pin,
    input wire logic irq
);
    logic start;
    logic mapped;
    logic is_con;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // address decode and access start
    assign start = psel && penable && !pready;
    assign is_con = paddr >= 12'h040 && paddr < 12'(64 + 16 * NCH) && paddr[3:0] == 4'h0;
    assign mapped = paddr[1:0] == 2'b00 && (paddr < 12'h010
        || (paddr >= 12'h040 && paddr < 12'(64 + 16 * NCH) && paddr[3:2] != 2'b11));
    a_ready_one_wait: assert property (start |=> pready) else $error("no answer after one wait state");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_needs_access: assert property (pready |-> $past(start)) else $error("ready without access");
    a_err_unmapped: assert property (start && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (start && mapped |=> !pslverr) else $error("mapped access refused");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    a_timer_upper_zero: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:16] == 16'h0)
        else $error("timer upper bits set");
    a_con_fields_clean: assert property (pready && !pwrite && is_con |-> prdata[31:10] == 22'h0 && prdata[7:6] == 2'b00)
        else $error("control unused bits set");
    a_irq_mask_off: assert property (pready && pwrite && paddr == 12'h00c && pwdata == 32'h0 |-> ##[1:2] !irq)
        else $error("irq stays with mask cleared");
    // main scenarios
    c_refused: cover property (start && !mapped);
    c_irq: cover property ($rose(irq));
    c_pin_edge: cover property ($changed(evt_pin));
    c_time_read: cover property (pready && !pwrite && paddr[3:0] == 4'h4 && paddr >= 12'h040);
endmodule
bind ecc_top ecc_top_chk #(.NCH(NCH), .TW(TW)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_pin(evt_pin), .irq(irq));

/* sim/ecc_top_tb.sv */
`timescale 1ns/1ps
module ecc_top_tb;
    import ecc_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, err;
    logic [3:0] flip = 4'h0;
    logic [3:0] evt_pin;
    logic [15:0] t1, t2, t3;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 79;
    always #10 pclk = ~pclk;
    ecc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt_pin(evt_pin), .irq(irq));
    ecc_pin_drv i_pin (.pclk(pclk), .presetn(presetn), .flip(flip), .evt_pin(evt_pin));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one apb transfer, bounded wait for ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    function automatic logic [11:0] ca(input int ch, input logic [11:0] sub);
        return 12'(12'h040 + 16 * ch) + sub;
    endfunction
    function automatic logic [15:0] second_time(input int ovw, input logic [15:0] b, input logic [15:0] c);
        return ovw ? c : b;
    endfunction
    // load the stopped timer, then make one edge on the chosen pins
    task automatic stamp(input logic [15:0] t, input logic [3:0] m);
        wr(ECC_TIMER_OFF, {16'h0, t});
        @(posedge pclk);
        flip <= m;
        @(posedge pclk);
        flip <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rdchk(ECC_TCTRL_OFF, 32'h0);
        rdchk(ECC_MASK_OFF, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        check(err, 1'b1);
        // capture path, overwrite off then on, random stamps
        for (int ovw = 0; ovw < 2; ovw++) begin
            t1 = 16'($random(seed));
            t2 = 16'($random(seed));
            t3 = 16'($random(seed));
            wr(ca(0, ECC_CON_OFF), 32'h00e | ovw);
            stamp(t1, 4'h1);
            stamp(t2, 4'h1);
            rdchk(ECC_PEND_OFF, 32'h1);
            wr(ECC_PEND_OFF, 32'h1);
            stamp(t3, 4'h1);
            rdchk(ca(0, ECC_CON_OFF), 32'h30e | ovw);
            rdchk(ECC_PEND_OFF, 32'h10000);
            wr(ECC_PEND_OFF, 32'h10000);
            rdchk(ca(0, ECC_TIME_OFF), {16'h0, t1});
            rdchk(ECC_PEND_OFF, 32'h1);
            rdchk(ca(0, ECC_TIME_OFF), {16'h0, second_time(ovw, t2, t3)});
            rdchk(ca(0, ECC_CON_OFF), 32'h00e | ovw);
            wr(ca(0, ECC_CON_OFF), 32'h0);
            wr(ECC_PEND_OFF, 32'h1);
        end
        // overwrite on, both stores full, a time read and an edge in the same cycle
        wr(ca(0, ECC_CON_OFF), 32'h00f);
        stamp(t1, 4'h1);
        stamp(t2, 4'h1);
        wr(ECC_PEND_OFF, 32'h1);
        wr(ECC_TIMER_OFF, {16'h0, t3});
        fork
            rdchk(ca(0, ECC_TIME_OFF), {16'h0, t1});
            begin
                @(posedge pclk);
                flip <= 4'h1;
                @(posedge pclk);
                flip <= 4'h0;
            end
        join
        rdchk(ECC_PEND_OFF, 32'h1);
        rdchk(ca(0, ECC_CON_OFF), 32'h30f);
        rdchk(ca(0, ECC_TIME_OFF), {16'h0, t2});
        rdchk(ca(0, ECC_TIME_OFF), {16'h0, t3});
        wr(ca(0, ECC_CON_OFF), 32'h0);
        wr(ECC_PEND_OFF, 32'h1);
        // a load onto the compare value makes no match, counting up or down does
        wr(ca(1, ECC_CMP_OFF), 32'h5);
        wr(ca(1, ECC_CON_OFF), 32'h10);
        wr(ECC_TIMER_OFF, 32'h5);
        rdchk(ECC_PEND_OFF, 32'h0);
        for (int dn = 0; dn < 2; dn++) begin
            wr(ECC_TIMER_OFF, dn ? 32'h9 : 32'h1);
            wr(ECC_TCTRL_OFF, dn ? 32'h3 : 32'h1);
            wr(ECC_TCTRL_OFF, 32'h0);
            rdchk(ECC_PEND_OFF, 32'h2);
            wr(ECC_PEND_OFF, 32'h2);
        end
        // channel 2 resets the running timer to zero; compare at zero stays quiet
        wr(ca(1, ECC_CMP_OFF), 32'h0);
        wr(ca(2, ECC_CON_OFF), 32'h26);
        wr(ECC_TCTRL_OFF, 32'h1);
        @(posedge pclk);
        flip <= 4'h4;
        @(posedge pclk);
        flip <= 4'h0;
        wr(ECC_TCTRL_OFF, 32'h0);
        wr(ca(2, ECC_CON_OFF), 32'h0); // timer writes only once no channel resets it
        rdchk(ECC_PEND_OFF, 32'h4);
        // interrupt raised, masked, cleared
        wr(ECC_MASK_OFF, 32'h4);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1);
        wr(ECC_MASK_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        wr(ECC_MASK_OFF, 32'h4);
        wr(ECC_PEND_OFF, 32'h4);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        rdchk(ECC_PEND_OFF, 32'h0);
        report_and_stop();
    end
endmodule
